// ===== logic/ipvic_ctrl.sv
// Prioritized vectored interrupt controller with APB register access
//
// Notes on behaviour
// R1 - Vector word: high byte at even address, low byte at next odd one.
// R2 - Reset vector 0002H, watchdog 0004H, illegal trap 0006H; reset and trap unmaskable.
// R3 - Peripherals take 0008H-0016H: timers 2,1,0, serial0 rx/tx, twowire, sync, converter.
// R4 - Eight port A/D pin edge sources take 0018H-0026H, pin 7 first.
// R5 - Lowest group 0028H-0036H: timer3, serial1 rx/tx, DMA, port C pins both edges.
// R6 - Global enable set by enable, return-from-interrupt or software write of one.
// R7 - Global enable cleared by disable, acknowledge, write zero, reset, trap, illegal trap.
// R8 - Three programmable levels; level 3 highest, level 1 lowest.
// R9 - Higher level always wins; same level resolved by fixed vector order.
// R10 - Reset, enabled watchdog and illegal trap beat all programmable requests.
// R11 - Each source pulses its request for exactly one clock.
// R12 - A request pulse sets and holds its pending bit.
// R13 - Acknowledge clears the pending bit until the source pulses again.
// R14 - Software writing zero to a pending bit clears that request.
// R15 - Software writing one raises the request like a hardware pulse.
// R16 - Only with global enable set are enabled requests forwarded; bits stay readable.
// R17 - Software updates pending bits with one read-modify-write to avoid losses.
// R18 - Watchdog is outside the request, enable and priority registers.
// R19 - First request register at FC0H, reset zero, timer2 in bit 7 down to converter.
// R20 - Upper/lower enable pair: 00 off, 01/10/11 levels 1/2/3.
// R21 - Per pin number only port A or port D feeds the pin interrupt.
// R22 - Every cycle the best pending enabled request and its vector are offered.
`timescale 1ns/10ps
`default_nettype none
module ipvic_ctrl
  import ipvic_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [GRP_W-1:0]  periphIrq0,
  input  wire logic [PC_N-1:0]   periphIrq2,
  input  wire logic [GRP_W-1:0]  portA,
  input  wire logic [GRP_W-1:0]  portD,
  input  wire logic [PC_N-1:0]   portC,
  input  wire logic              wdtIrq,
  input  wire logic              illegalTrap,
  input  wire logic              trapInstr,
  input  wire logic              enableIntsInstr,
  input  wire logic              disableIntsInstr,
  input  wire logic              returnFromIntInstr,
  input  wire logic              cpuAck,
  output logic                   irqReq,
  output logic      [15:0]       irqVecHi,
  output logic      [15:0]       irqVecLo,
  output logic                   globalIntEnable
);

  ipvic_state_t st_reg;
  ipvic_state_t st_next;

  ipvic_pick_if pk ();

  logic [GRP_W-1:0] grpSet [GRP_N];
  logic [GRP_W-1:0] pinSel;
  logic [GRP_W-1:0] pinEdge;
  logic [PC_N-1:0]  pcEdge;
  logic [SRC_N-1:0] hwSet;
  logic [SRC_N-1:0] ackMask;
  logic [GRP_W-1:0] rdByte;
  logic             wrEn;
  logic             mapped;
  logic             ackAny;

  ipvic_picker u_picker (
    .pk (pk.picker)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    wrEn    = psel & penable & pwrite;
    mapped  = 1'b0;
    rdByte  = '0;
    hwSet   = '0;
    ackMask = '0;
    ackAny  = cpuAck & st_reg.irqReq;

    // Pin sources: one of port A or D per pin, edge polarity per pin
    pinSel  = (st_reg.portSel & portD) | (~st_reg.portSel & portA);    // [R21]
    pinEdge = (pinSel ^ st_reg.pinPrev) & ~(pinSel ^ st_reg.edgeRise); // [R4]
    pcEdge  = portC ^ st_reg.pcPrev;                                    // [R5]
    st_next.pinPrev = pinSel;
    st_next.pcPrev  = portC;

    grpSet[0] = periphIrq0;                                             // [R3] [R19]
    grpSet[1] = pinEdge;
    grpSet[2] = {periphIrq2, pcEdge};
    for (int g = 0; g < GRP_N; g++)
    begin
      for (int b = 0; b < GRP_W; b++)
      begin
        hwSet[g * GRP_W + GRP_W - 1 - b] = grpSet[g][b];
      end
    end

    // Acknowledge of a programmable winner
    if (ackAny && st_reg.winCode < IDX_W'(SRC_N))
    begin
      ackMask[st_reg.winCode] = 1'b1;                                   // [R13]
    end

    // Register decode, write and read
    for (int g = 0; g < GRP_N; g++)
    begin
      for (int b = 0; b < GRP_W; b++)
      begin
        if (paddr == ADR_REQ[g])
        begin
          mapped    = 1'b1;
          rdByte[b] = st_reg.pend[g * GRP_W + GRP_W - 1 - b];
          if (wrEn)
          begin
            st_next.pend[g * GRP_W + GRP_W - 1 - b] = pwdata[b];        // [R14] [R15]
          end
        end
        if (paddr == ADR_ENU[g])
        begin
          mapped    = 1'b1;
          rdByte[b] = st_reg.enU[g * GRP_W + GRP_W - 1 - b];
          if (wrEn)
          begin
            st_next.enU[g * GRP_W + GRP_W - 1 - b] = pwdata[b];         // [R20]
          end
        end
        if (paddr == ADR_ENL[g])
        begin
          mapped    = 1'b1;
          rdByte[b] = st_reg.enL[g * GRP_W + GRP_W - 1 - b];
          if (wrEn)
          begin
            st_next.enL[g * GRP_W + GRP_W - 1 - b] = pwdata[b];
          end
        end
      end
    end
    if (paddr == ADR_PSEL)
    begin
      mapped = 1'b1;
      rdByte = st_reg.portSel;
      if (wrEn)
      begin
        st_next.portSel = pwdata[GRP_W-1:0];                            // [R21]
      end
    end
    if (paddr == ADR_EDGE)
    begin
      mapped = 1'b1;
      rdByte = st_reg.edgeRise;
      if (wrEn)
      begin
        st_next.edgeRise = pwdata[GRP_W-1:0];
      end
    end
    if (paddr == ADR_CTRL)
    begin
      mapped = 1'b1;
      rdByte[CTRL_GIE_BIT]   = st_reg.gie;
      rdByte[CTRL_WDTEN_BIT] = st_reg.wdtEn;
      if (wrEn)
      begin
        st_next.gie   = pwdata[CTRL_GIE_BIT];                           // [R6] [R7]
        st_next.wdtEn = pwdata[CTRL_WDTEN_BIT];
      end
    end

    // Read data captured in the setup phase
    if (psel && !penable && !pwrite)
    begin
      st_next.prdata = {{(DATA_W - GRP_W){1'b0}}, rdByte};
    end

    // Pending bits: acknowledge clears, a new pulse wins over any clear
    st_next.pend = (st_next.pend & ~ackMask) | hwSet;                   // [R12] [R13]

    // Global enable
    if (disableIntsInstr || ackAny || trapInstr || illegalTrap)
    begin
      st_next.gie = 1'b0;                                               // [R7]
    end
    if (enableIntsInstr || returnFromIntInstr)
    begin
      st_next.gie = 1'b1;                                               // [R6]
    end

    // Unmaskable and watchdog sources live outside the request registers
    if (ackAny && st_reg.winCode == WIN_RESET)
    begin
      st_next.rstPend = 1'b0;                                           // [R2]
    end
    if (ackAny && st_reg.winCode == WIN_WDT)
    begin
      st_next.wdtPend = 1'b0;
    end
    if (ackAny && st_reg.winCode == WIN_TRAP)
    begin
      st_next.trapPend = 1'b0;
    end
    st_next.wdtPend  = st_next.wdtPend | wdtIrq;                        // [R18]
    st_next.trapPend = st_next.trapPend | illegalTrap;

    // Winner is formed from the next state so it matches the registers
    pk.req   = st_next.pend & {SRC_N{st_next.gie}};                     // [R16]
    pk.lvlHi = st_next.enU;
    pk.lvlLo = st_next.enL;

    st_next.irqReq = 1'b1;
    if (st_next.rstPend)
    begin
      st_next.winCode = WIN_RESET;                                      // [R10]
      st_next.vecHi   = VEC_RESET;                                      // [R2]
    end
    else if (st_next.wdtPend && st_next.wdtEn)
    begin
      st_next.winCode = WIN_WDT;
      st_next.vecHi   = VEC_WDT;
    end
    else if (st_next.trapPend)
    begin
      st_next.winCode = WIN_TRAP;
      st_next.vecHi   = VEC_TRAP;
    end
    else if (pk.hit)
    begin
      st_next.winCode = pk.idx;                                         // [R22]
      st_next.vecHi   = VEC_FIRST + (16'(pk.idx) << VEC_SHIFT);         // [R3] [R4] [R5]
    end
    else
    begin
      st_next.irqReq  = 1'b0;
      st_next.winCode = '0;
      st_next.vecHi   = '0;
    end
    st_next.vecLo = st_next.vecHi | VEC_ODD;                            // [R1]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= ST_RST;                                                 // [R19]
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata          = st_reg.prdata;
  assign pready          = 1'b1;
  assign pslverr         = psel & penable & ~mapped;
  assign irqReq          = st_reg.irqReq;
  assign irqVecHi        = st_reg.vecHi;
  assign irqVecLo        = st_reg.vecLo;
  assign globalIntEnable = st_reg.gie;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_ack_prog;
    cpuAck && irqReq && st_reg.winCode < IDX_W'(SRC_N) && !hwSet[st_reg.winCode];
  endsequence

  sequence s_wr_req0_zero;
    wrEn && paddr == ADR_REQ[0] && !pwdata[GRP_W-1] && !periphIrq0[GRP_W-1];
  endsequence

  sequence s_wr_req0_one;
    wrEn && paddr == ADR_REQ[0] && pwdata[GRP_W-1] && !cpuAck;
  endsequence

  logic [IDX_W-1:0] ackCode;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ackCode <= '0;
    end
    else
    begin
      ackCode <= st_reg.winCode;
    end
  end

  a_vec_odd_pair: assert property (irqReq |-> // [R1]
    irqVecLo == (irqVecHi | VEC_ODD) && !irqVecHi[0])
    else $error("vector low byte address is not the odd neighbour");

  a_reset_vector: assert property (irqReq && st_reg.winCode == WIN_RESET |-> // [R2]
    irqVecHi == VEC_RESET)
    else $error("reset winner without reset vector");

  a_prog_vector: assert property (irqReq && st_reg.winCode < IDX_W'(SRC_N) |-> // [R3]
    irqVecHi == VEC_FIRST + (16'(st_reg.winCode) << VEC_SHIFT))
    else $error("vector does not follow fixed table order");

  a_ei_sets_gie: assert property (enableIntsInstr || returnFromIntInstr |=> // [R6]
    globalIntEnable)
    else $error("global enable not set by enable instruction");

  a_ack_clr_gie: assert property (cpuAck && irqReq && !enableIntsInstr && // [R7]
    !returnFromIntInstr |=> !globalIntEnable)
    else $error("acknowledge did not clear global enable");

  a_dis_clr_gie: assert property ((disableIntsInstr || trapInstr || illegalTrap) && // [R7]
    !enableIntsInstr && !returnFromIntInstr |=> !globalIntEnable)
    else $error("disable or trap did not clear global enable");

  a_unmask_first: assert property (irqReq && st_reg.winCode < IDX_W'(SRC_N) |-> // [R10]
    !st_reg.rstPend && !st_reg.trapPend && !(st_reg.wdtPend && st_reg.wdtEn))
    else $error("programmable request beat an unmaskable one");

  a_pulse_sets: assert property (periphIrq0[GRP_W-1] |=> // [R12]
    st_reg.pend[0] ##1 (st_reg.pend[0] || $past(cpuAck)))
    else $error("timer 2 pulse did not set and hold its pending bit");

  a_ack_clears: assert property (s_ack_prog |=> !st_reg.pend[ackCode]) // [R13]
    else $error("acknowledge did not clear pending bit");

  a_sw_clear: assert property (s_wr_req0_zero |=> !st_reg.pend[0]) // [R14]
    else $error("write of zero did not clear pending bit");

  a_sw_set: assert property (s_wr_req0_one |=> st_reg.pend[0]) // [R15]
    else $error("write of one did not raise pending bit");

  a_gie_gates: assert property (irqReq && st_reg.winCode < IDX_W'(SRC_N) |-> // [R16]
    globalIntEnable && (st_reg.enU[st_reg.winCode] || st_reg.enL[st_reg.winCode]))
    else $error("request forwarded while disabled");

endmodule
`default_nettype wire

// ===== logic/ipvic_pkg.sv
// Constants, register map and state type of the prioritized vector interrupt controller
package ipvic_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int SRC_N  = 24;
  localparam int GRP_N  = 3;
  localparam int GRP_W  = 8;
  localparam int IDX_W  = 5;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PC_N   = 4;
  localparam int LVL_N  = 3;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADR_REQ [GRP_N] = '{12'hFC0, 12'hFCC, 12'hFD8};
  localparam logic [11:0] ADR_ENU [GRP_N] = '{12'hFC4, 12'hFD0, 12'hFDC};
  localparam logic [11:0] ADR_ENL [GRP_N] = '{12'hFC8, 12'hFD4, 12'hFE0};
  localparam logic [11:0] ADR_PSEL = 12'hFE4;
  localparam logic [11:0] ADR_EDGE = 12'hFE8;
  localparam logic [11:0] ADR_CTRL = 12'hFEC;

  localparam int CTRL_GIE_BIT   = 7;
  localparam int CTRL_WDTEN_BIT = 0;
  localparam logic [7:0] REG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Vector addresses and winner codes
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'h0002;
  localparam logic [15:0] VEC_WDT   = 16'h0004;
  localparam logic [15:0] VEC_TRAP  = 16'h0006;
  localparam logic [15:0] VEC_FIRST = 16'h0008;
  localparam logic [15:0] VEC_ODD   = 16'h0001;
  localparam int          VEC_SHIFT = 1;

  localparam logic [4:0] WIN_RESET = 5'h18;
  localparam logic [4:0] WIN_WDT   = 5'h19;
  localparam logic [4:0] WIN_TRAP  = 5'h1A;

  // ----------------------------------------------------------------
  // State of the controller
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SRC_N-1:0]  pend;
    logic [SRC_N-1:0]  enU;
    logic [SRC_N-1:0]  enL;
    logic [GRP_W-1:0]  portSel;
    logic [GRP_W-1:0]  edgeRise;
    logic              gie;
    logic              wdtEn;
    logic              rstPend;
    logic              wdtPend;
    logic              trapPend;
    logic [GRP_W-1:0]  pinPrev;
    logic [PC_N-1:0]   pcPrev;
    logic              irqReq;
    logic [IDX_W-1:0]  winCode;
    logic [15:0]       vecHi;
    logic [15:0]       vecLo;
    logic [DATA_W-1:0] prdata;
  } ipvic_state_t;

  localparam ipvic_state_t ST_RST = '{
    rstPend : 1'b1,
    irqReq  : 1'b1,
    winCode : WIN_RESET,
    vecHi   : VEC_RESET,
    vecLo   : VEC_RESET | VEC_ODD,
    default : '0
  };

endpackage

// ===== logic/ipvic_pick_if.sv
// Carrier between the controller and its priority picker
`timescale 1ns/10ps
`default_nettype none
interface ipvic_pick_if;
  import ipvic_pkg::*;
  logic [SRC_N-1:0] req;
  logic [SRC_N-1:0] lvlHi;
  logic [SRC_N-1:0] lvlLo;
  logic             hit;
  logic [IDX_W-1:0] idx;
  modport ctrl   (output req, output lvlHi, output lvlLo, input hit, input idx);
  modport picker (input req, input lvlHi, input lvlLo, output hit, output idx);
endinterface
`default_nettype wire

// ===== logic/ipvic_picker.sv
// Three-level priority picker with fixed order inside each level
`timescale 1ns/10ps
`default_nettype none
module ipvic_picker
  import ipvic_pkg::*;
(
  ipvic_pick_if.picker pk
);

  logic [SRC_N-1:0] lvlHit [1:LVL_N];

  // ----------------------------------------------------------------
  // Per-source level decode
  // ----------------------------------------------------------------
  for (genvar i = 0; i < SRC_N; i++)
  begin : g_src
    assign lvlHit[3][i] = pk.req[i] & pk.lvlHi[i] & pk.lvlLo[i];   // [R20]
    assign lvlHit[2][i] = pk.req[i] & pk.lvlHi[i] & ~pk.lvlLo[i];
    assign lvlHit[1][i] = pk.req[i] & ~pk.lvlHi[i] & pk.lvlLo[i];
  end

  // ----------------------------------------------------------------
  // Later hits overwrite: highest level, then lowest index wins
  // ----------------------------------------------------------------
  always_comb
  begin
    pk.hit = 1'b0;
    pk.idx = '0;
    for (int l = 1; l <= LVL_N; l++)
    begin
      for (int i = SRC_N - 1; i >= 0; i--)
      begin
        if (lvlHit[l][i])
        begin
          pk.hit = 1'b1;                                           // [R8] [R9]
          pk.idx = IDX_W'(i);
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== testbench/ipvic_cpu_model.sv
// Processor model that acknowledges offered interrupt vectors
`timescale 1ns/10ps
`default_nettype none
module ipvic_cpu_model
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        irqReq,
  input  wire logic [15:0] irqVecHi,
  input  wire logic [31:0] ackLimit,
  input  wire logic [31:0] ackDelay,
  output logic             cpuAck,
  output int               ackCnt,
  output logic      [15:0] lastVec
);
  int waitCnt;

  // Acks after ackDelay cycles, never beyond ackLimit acks
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpuAck  <= 1'b0;
      ackCnt  <= 0;
      waitCnt <= 0;
      lastVec <= 16'h0000;
    end
    else if (cpuAck)
    begin
      cpuAck  <= 1'b0;
      lastVec <= irqVecHi;
      ackCnt  <= ackCnt + 1;
      waitCnt <= 0;
    end
    else if (irqReq && ackCnt < ackLimit)
    begin
      if (waitCnt >= ackDelay)
        cpuAck <= 1'b1;
      waitCnt <= waitCnt + 1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/ipvic_ctrl_bench.sv
// Self-checking testbench of the vectored interrupt controller
`timescale 1ns/10ps
`default_nettype none
module ipvic_ctrl_bench
  import ipvic_pkg::*;
;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, slv;
  logic        cpuAck, irqReq, globalIntEnable;
  logic [5:0]  ctl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  periphIrq0, portA, portD;
  logic [3:0]  periphIrq2, portC;
  logic [15:0] irqVecHi, irqVecLo, lastVec;
  int          ackLimit, ackDelay, ackCnt, miscompares, totalChecks, cycles;

  ipvic_ctrl uut (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periphIrq0(periphIrq0), .periphIrq2(periphIrq2), .portA(portA), .portD(portD),
    .portC(portC), .wdtIrq(ctl[0]), .illegalTrap(ctl[1]), .trapInstr(ctl[2]),
    .enableIntsInstr(ctl[3]), .disableIntsInstr(ctl[4]), .returnFromIntInstr(ctl[5]),
    .cpuAck(cpuAck), .irqReq(irqReq), .irqVecHi(irqVecHi), .irqVecLo(irqVecLo),
    .globalIntEnable(globalIntEnable));

  ipvic_cpu_model cpu (.clk(clk), .rst_b(rst_b), .irqReq(irqReq), .irqVecHi(irqVecHi),
    .ackLimit(ackLimit), .ackDelay(ackDelay), .cpuAck(cpuAck), .ackCnt(ackCnt),
    .lastVec(lastVec));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One APB transfer; read data and error taken at the pready edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask

  // One-cycle pulses on control and source lines
  task pulse(input logic [5:0] c, input logic [7:0] p0, input logic [3:0] p2);
    @(posedge clk);
    ctl <= c; periphIrq0 <= p0; periphIrq2 <= p2;
    @(posedge clk);
    ctl <= '0; periphIrq0 <= '0; periphIrq2 <= '0;
    @(negedge clk);
  endtask

  task pins(input logic [7:0] a, input logic [7:0] d, input logic [3:0] c);
    @(posedge clk);
    portA <= a; portD <= d; portC <= c;
    repeat (4) @(negedge clk);
  endtask

  // Re-enables globally, lets the processor take one vector and checks it
  task serve(input logic [15:0] v);
    int n;
    n = ackLimit + 1;
    pulse(6'h20, 8'h00, 4'h0);
    @(posedge clk);
    ackLimit <= n;
    for (int i = 0; i < 64 && ackCnt != n; i++) @(negedge clk);
    check(ackCnt, n);
    check(lastVec, v);
    check(globalIntEnable, 1'b0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      $display("ERROR %0t: timeout", $time);
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    ctl = '0; periphIrq0 = '0; periphIrq2 = '0; portA = '0; portD = '0; portC = '0;
    ackLimit = 0; ackDelay = 0; miscompares = 0; totalChecks = 0; cycles = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check(irqReq, 1'b1);
    check(irqVecHi, VEC_RESET);
    check(irqVecLo, 16'h0003);
    check(globalIntEnable, 1'b0);
    apb(ADR_REQ[0], 1'b0, 0);
    check(rd, 32'h0);
    serve(16'h0002);
    check(irqReq, 1'b0);
    $display("test reset done");

    pulse(6'h00, 8'h80, 4'h0);
    apb(ADR_REQ[0], 1'b0, 0);
    check(rd, 32'h80);
    check(irqReq, 1'b0);
    apb(ADR_ENU[0], 1'b1, 32'h80);
    apb(ADR_CTRL, 1'b1, 32'h80);
    @(negedge clk);
    check(globalIntEnable, 1'b1);
    check(irqVecHi, 16'h0008);
    check(irqVecLo, 16'h0009);
    serve(16'h0008);
    apb(ADR_REQ[0], 1'b0, 0);
    check(rd, 32'h0);
    $display("test pending done");

    apb(ADR_ENU[0], 1'b1, 0);
    apb(ADR_ENL[0], 1'b1, 32'hFF);
    apb(ADR_REQ[0], 1'b1, 32'hFF);
    for (int i = 0; i < 8; i++) serve(16'h0008 + 16'(2 * i));
    apb(ADR_ENU[0], 1'b1, 32'h11);
    apb(ADR_ENL[0], 1'b1, 32'h81);
    apb(ADR_REQ[0], 1'b1, 32'hFF);
    serve(16'h0016);
    serve(16'h000E);
    serve(16'h0008);
    pulse(6'h20, 8'h00, 4'h0);
    check(globalIntEnable, 1'b1);
    check(irqReq, 1'b0);
    apb(ADR_REQ[0], 1'b0, 0);
    check(rd, 32'h6E);
    apb(ADR_REQ[0], 1'b1, 0);
    apb(ADR_REQ[0], 1'b0, 0);
    check(rd, 32'h0);
    $display("test priority done");

    apb(ADR_REQ[0], 1'b1, 32'h01);
    apb(ADR_CTRL, 1'b1, 32'h81);
    pulse(6'h03, 8'h00, 4'h0);
    check(globalIntEnable, 1'b0);
    serve(16'h0004);
    serve(16'h0006);
    apb(ADR_REQ[0], 1'b0, 0);
    check(rd, 32'h01);
    serve(16'h0016);
    apb(ADR_CTRL, 1'b1, 0);
    pulse(6'h21, 8'h00, 4'h0);
    check(irqReq, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      pulse(6'h08, 8'h00, 4'h0);
      check(globalIntEnable, 1'b1);
      if (k < 2)
        pulse(k == 0 ? 6'h10 : 6'h04, 8'h00, 4'h0);
      else
        apb(ADR_CTRL, 1'b1, 0);
      check(globalIntEnable, 1'b0);
    end
    $display("test special done");

    ackDelay = 5;
    apb(ADR_ENU[1], 1'b1, 32'h80);
    apb(ADR_EDGE, 1'b1, 32'h80);
    apb(ADR_PSEL, 1'b1, 0);
    pins(8'h00, 8'h80, 4'h0);
    apb(ADR_REQ[1], 1'b0, 0);
    check(rd, 32'h0);
    pins(8'h80, 8'h80, 4'h0);
    apb(ADR_REQ[1], 1'b0, 0);
    check(rd, 32'h80);
    serve(16'h0018);
    pins(8'h00, 8'h80, 4'h0);
    apb(ADR_REQ[1], 1'b0, 0);
    check(rd, 32'h0);
    apb(ADR_EDGE, 1'b1, 0);
    apb(ADR_PSEL, 1'b1, 32'h80);
    pins(8'h00, 8'h00, 4'h0);
    serve(16'h0018);
    apb(ADR_ENL[2], 1'b1, 32'h81);
    pins(8'h00, 8'h80, 4'h1);
    serve(16'h0036);
    pins(8'h00, 8'h80, 4'h0);
    serve(16'h0036);
    pulse(6'h00, 8'h00, 4'h8);
    serve(16'h0028);
    apb(ADR_REQ[0], 1'b1, 32'h80);
    apb(ADR_CTRL, 1'b1, 32'h80);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check(globalIntEnable, 1'b0);
    check(irqVecHi, VEC_RESET);
    apb(ADR_REQ[0], 1'b0, 0);
    check(rd, 32'h0);
    apb(12'h000, 1'b0, 0);
    check(slv, 1'b1);
    check(rd, 32'h0);
    $display("test pins done");
    give_verdict;
  end
endmodule
`default_nettype wire
